// [supply_ctrl_pkg.sv]
// package: register map, field widths, codes and timing for the supply control block
package supply_ctrl_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL       = 8'h00; // cmd strobes / config
  localparam logic [7:0] ADDR_STATUS     = 8'h04; // fault and output state
  localparam logic [7:0] ADDR_CURR_SET   = 8'h08; // current setpoint
  localparam logic [7:0] ADDR_VOLT_SET   = 8'h0C; // voltage setpoint (from recall)
  localparam logic [7:0] ADDR_OC_LIMIT   = 8'h10; // overcurrent limit
  localparam logic [7:0] ADDR_OC_CMD     = 8'h14; // limit keyword command
  localparam logic [7:0] ADDR_RAMP_UP    = 8'h18; // ramp-up time, tenths of second
  localparam logic [7:0] ADDR_RAMP_DN    = 8'h1C; // ramp-down time, tenths of second
  localparam logic [7:0] ADDR_PRE_IDX    = 8'h20; // preset index
  localparam logic [7:0] ADDR_PRE_VOLT   = 8'h24; // preset voltage of indexed location
  localparam logic [7:0] ADDR_PRE_CURR   = 8'h28; // preset current of indexed location
  localparam logic [7:0] ADDR_PRE_LIST   = 8'h2C; // voltage high half, current low half
  // ctrl register bit positions
  localparam int CTRL_OUT_EN    = 0; // output enable request
  localparam int CTRL_FOLDBACK  = 1; // foldback enable
  localparam int CTRL_PON_LAST  = 2; // power-on policy: 1 = restore last
  localparam int CTRL_CLR_FAULT = 3; // fault latch clear strobe
  localparam int CTRL_DEV_RST   = 4; // device reset strobe
  localparam int CTRL_PRE_CLR   = 5; // preset clear strobe
  localparam int CTRL_PRE_REC   = 6; // preset recall strobe
  // status bit positions
  localparam int ST_OUT_ON  = 0;
  localparam int ST_TRIP    = 1;
  localparam int ST_OV_L    = 2;
  localparam int ST_OC_L    = 3;
  localparam int ST_OT_L    = 4;
  localparam int ST_AC_L    = 5;
  localparam int ST_FOLD    = 6;
  // widths and scales (values in units of 1/1000 of rated, 16 bit)
  localparam int          VAL_W        = 16;
  localparam logic [15:0] RATED        = 16'h03E8; // 1000 = 100 % rated
  localparam logic [15:0] OC_MIN_VAL   = 16'h0064; // 10 %
  localparam logic [15:0] OC_MAX_VAL   = 16'h044C; // 110 %
  localparam logic [7:0]  RAMP_MAX     = 8'h63;    // 9.9 s in tenths
  localparam int          PRE_DEPTH    = 16;
  localparam logic [1:0]  OC_KEY_MIN   = 2'h1;
  localparam logic [1:0]  OC_KEY_MAX   = 2'h2;
  // foldback trip delay
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          TRIP_MS      = 500;      // 0.5 second
  localparam int          TRIP_CYC     = CLK_HZ / 1000 * TRIP_MS;
  // command bus carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
  // fault inputs from the power stage
  typedef struct packed {
    logic ov; // overvoltage
    logic oc; // overcurrent hardware fault
    logic ot; // overtemperature
    logic ac; // mains failure
  } fault_in_t;
endpackage : supply_ctrl_pkg

// [supply_host_model.sv]
// partner model: remote host issuing one-cycle register commands and queries
`timescale 1ns/100ps
module supply_host_model (
  input  wire logic                 i_clk_sys, // system clock
  input  wire logic [31:0]          i_rdata,   // answer from the block
  output supply_ctrl_pkg::bus_req_t o_bus      // request to the block
);
  initial o_bus = '0;
  // write: strobe for one cycle, then idle lines scrambled so stale data is not reused
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  // read: strobe for one cycle, answer taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_bus <= '{addr: ~a, wdata: o_bus.wdata, wr: 1'b0, rd: 1'b0};
    // answer stands from this edge to the next; take it mid-cycle where it is settled
    @(negedge i_clk_sys);
    d = i_rdata;
  endtask : rd
endmodule : supply_host_model

// [supply_protect_preset_ctrl.sv]
// supply control: fault latch, current limits, foldback, ramps, presets
//
// Contract
// - clear command clears latched output-off faults
// - ov/oc always latch; ot/ac latch if off-policy
// - restore-last policy: ot/ac never latched
// - clear only when all fault sources gone
// - successful clear restores pre-fault output enable
// - current setpoint zero to rated, read back
// - limit 10 to 110 percent; max keyword
// - min keyword copies current setpoint into limit
// - device reset returns limit to maximum
// - remote limit stays active in local mode
// - foldback trips after 0.5 s in cc
// - foldback query reads one when enabled
// - trip query reads one when tripped
// - ramp-down time 0.0 to 9.9 seconds
// - ramp-up time 0.0 to 9.9 seconds
// - preset clear erases all locations at once
// - sixteen presets each voltage and current
// - preset current store and read back
// - preset voltage store and read back
// - recall when off loads setpoints only
// - recall when on drives output immediately
// - listing returns voltage then current
// - off-policy powers up with output disabled
`timescale 1ns/100ps
module supply_protect_preset_ctrl #(
  parameter int TRIP_CYCLES = supply_ctrl_pkg::TRIP_CYC // foldback delay, shortenable
) (
  input  wire logic                      i_clk_sys,   // system clock 10 MHz
  input  wire logic                      i_nrst,      // sync reset, active low
  input  wire supply_ctrl_pkg::bus_req_t i_bus,       // register request
  input  wire supply_ctrl_pkg::fault_in_t i_fault,    // live fault conditions
  input  wire logic                      i_cc_mode,   // stage in constant current
  input  wire logic [15:0]               i_meas_curr, // measured current
  input  wire logic                      i_local,     // front panel local mode
  output logic [31:0]                    o_rdata,     // read data, cycle after strobe
  output logic                           o_out_en,    // power stage output enable
  output logic [15:0]                    o_volt_set,  // voltage setpoint to stage
  output logic [15:0]                    o_curr_set,  // current setpoint to stage
  output logic [15:0]                    o_disp_volt, // voltage display value
  output logic [15:0]                    o_disp_curr, // current display value
  output logic [7:0]                     o_ramp_up,   // ramp-up time to stage
  output logic [7:0]                     o_ramp_dn    // ramp-down time to stage
);

  // clamp a value into an inclusive range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) begin
      clamp16 = lo;
    end else if (v > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v;
    end
  endfunction : clamp16

  // clamp a ramp time to 9.9 s
  function automatic logic [7:0] clamp_ramp(input logic [31:0] v);
    if (v > {24'h000000, supply_ctrl_pkg::RAMP_MAX}) begin
      clamp_ramp = supply_ctrl_pkg::RAMP_MAX;
    end else begin
      clamp_ramp = v[7:0];
    end
  endfunction : clamp_ramp

  // decoded write strobes
  logic wr_ctrl;
  logic wr_curr;
  logic wr_lim;
  logic wr_key;
  logic wr_rup;
  logic wr_rdn;
  logic wr_idx;
  logic wr_pv;
  logic wr_pc;

  // state registers
  logic        out_req_r;    // software output enable
  logic        foldback_r;   // foldback enable
  logic        pon_last_r;   // power-on policy restore-last
  logic        ov_l_r;       // latched overvoltage
  logic        oc_l_r;       // latched overcurrent
  logic        ot_l_r;       // latched overtemperature
  logic        ac_l_r;       // latched mains failure
  logic        trip_r;       // foldback trip flag
  logic        pre_fault_r;  // output enable saved at fault entry
  logic [15:0] curr_r;       // current setpoint
  logic [15:0] volt_r;       // voltage setpoint
  logic [15:0] lim_r;        // overcurrent limit
  logic [7:0]  rup_r;        // ramp-up tenths
  logic [7:0]  rdn_r;        // ramp-down tenths
  logic [3:0]  idx_r;        // preset index
  logic [31:0] trip_cnt_r;   // foldback timer
  logic [15:0] pre_v [supply_ctrl_pkg::PRE_DEPTH]; // preset voltages
  logic [15:0] pre_c [supply_ctrl_pkg::PRE_DEPTH]; // preset currents

  // combinational helpers
  logic any_latched;
  logic src_active;
  logic clr_ok;
  logic latch_new;
  logic over_lim;

  // address decode for writes
  always_comb begin
    wr_ctrl = 1'b0;
    wr_curr = 1'b0;
    wr_lim  = 1'b0;
    wr_key  = 1'b0;
    wr_rup  = 1'b0;
    wr_rdn  = 1'b0;
    wr_idx  = 1'b0;
    wr_pv   = 1'b0;
    wr_pc   = 1'b0;
    if (!i_bus.wr) begin
      wr_ctrl = 1'b0;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_CURR_SET) begin
      wr_curr = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_OC_LIMIT) begin
      wr_lim = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_OC_CMD) begin
      wr_key = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_RAMP_UP) begin
      wr_rup = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_RAMP_DN) begin
      wr_rdn = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_IDX) begin
      wr_idx = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_VOLT) begin
      wr_pv = 1'b1;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_CURR) begin
      wr_pc = 1'b1;
    end
  end

  // fault bookkeeping
  always_comb begin
    any_latched = ov_l_r | oc_l_r | ot_l_r | ac_l_r | trip_r;
    src_active  = i_fault.ov | i_fault.oc | i_fault.ot | i_fault.ac
                | (foldback_r & i_cc_mode & over_lim);
    // clear accepted only with every source gone
    clr_ok      = wr_ctrl & i_bus.wdata[supply_ctrl_pkg::CTRL_CLR_FAULT]
                & ~src_active;
    latch_new   = i_fault.ov | i_fault.oc
                | (~pon_last_r & (i_fault.ot | i_fault.ac));
    over_lim    = i_meas_curr > lim_r;
  end

  // configuration bits; off-policy reset leaves output disabled
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      out_req_r  <= 1'b0;
      foldback_r <= 1'b0;
      pon_last_r <= 1'b0;
    end else if (clr_ok) begin
      // successful clear puts back the enable held before the fault
      out_req_r  <= pre_fault_r;
      foldback_r <= i_bus.wdata[supply_ctrl_pkg::CTRL_FOLDBACK];
      pon_last_r <= i_bus.wdata[supply_ctrl_pkg::CTRL_PON_LAST];
    end else if (wr_ctrl) begin
      out_req_r  <= i_bus.wdata[supply_ctrl_pkg::CTRL_OUT_EN];
      foldback_r <= i_bus.wdata[supply_ctrl_pkg::CTRL_FOLDBACK];
      pon_last_r <= i_bus.wdata[supply_ctrl_pkg::CTRL_PON_LAST];
    end
  end

  // fault latches; a new fault wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ov_l_r <= 1'b0;
      oc_l_r <= 1'b0;
      ot_l_r <= 1'b0;
      ac_l_r <= 1'b0;
    end else begin
      ov_l_r <= i_fault.ov | (ov_l_r & ~clr_ok);
      oc_l_r <= i_fault.oc | (oc_l_r & ~clr_ok);
      // restore-last policy holds no temperature or mains latch
      ot_l_r <= ~pon_last_r & (i_fault.ot | (ot_l_r & ~clr_ok));
      ac_l_r <= ~pon_last_r & (i_fault.ac | (ac_l_r & ~clr_ok));
    end
  end

  // foldback timer and trip flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      trip_cnt_r <= 32'h00000000;
      trip_r     <= 1'b0;
    end else begin
      if (foldback_r && i_cc_mode && over_lim) begin
        if (trip_cnt_r < TRIP_CYCLES - 1) begin
          trip_cnt_r <= trip_cnt_r + 32'h00000001;
        end else begin
          trip_r <= 1'b1;
        end
      end else begin
        trip_cnt_r <= 32'h00000000; // disabled or condition gone: no trip
        if (clr_ok) begin
          trip_r <= 1'b0;
        end
      end
    end
  end

  // remember output enable at fault entry, restore after clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pre_fault_r <= 1'b0;
    end else if (!any_latched) begin
      pre_fault_r <= out_req_r;
    end
  end

  // output enable drive
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_out_en <= 1'b0;
    end else if (any_latched || latch_new) begin
      o_out_en <= 1'b0;
    end else begin
      o_out_en <= out_req_r; // out_req_r restored from pre_fault_r on clear
    end
  end

  // setpoints, limit and ramps; local mode does not touch the limit
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      curr_r <= 16'h0000;
      volt_r <= 16'h0000;
      lim_r  <= supply_ctrl_pkg::OC_MAX_VAL;
      rup_r  <= 8'h00;
      rdn_r  <= 8'h00;
    end else begin
      if (wr_ctrl && i_bus.wdata[supply_ctrl_pkg::CTRL_DEV_RST]) begin
        lim_r <= supply_ctrl_pkg::OC_MAX_VAL;
      end else if (wr_lim) begin
        lim_r <= clamp16(i_bus.wdata[15:0], supply_ctrl_pkg::OC_MIN_VAL,
                         supply_ctrl_pkg::OC_MAX_VAL);
      end else if (wr_key && i_bus.wdata[1:0] == supply_ctrl_pkg::OC_KEY_MAX) begin
        lim_r <= supply_ctrl_pkg::OC_MAX_VAL;
      end else if (wr_key && i_bus.wdata[1:0] == supply_ctrl_pkg::OC_KEY_MIN) begin
        lim_r <= curr_r;
      end
      if (wr_curr) begin
        curr_r <= clamp16(i_bus.wdata[15:0], 16'h0000, supply_ctrl_pkg::RATED);
      end else if (wr_ctrl && i_bus.wdata[supply_ctrl_pkg::CTRL_PRE_REC]) begin
        curr_r <= pre_c[idx_r];
      end
      if (wr_ctrl && i_bus.wdata[supply_ctrl_pkg::CTRL_PRE_REC]) begin
        volt_r <= pre_v[idx_r];
      end
      if (wr_rup) begin
        rup_r <= clamp_ramp(i_bus.wdata);
      end
      if (wr_rdn) begin
        rdn_r <= clamp_ramp(i_bus.wdata);
      end
    end
  end

  // preset index
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      idx_r <= 4'h0;
    end else if (wr_idx) begin
      idx_r <= i_bus.wdata[3:0];
    end
  end

  // preset memory; clear erases every location in one cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || (wr_ctrl && i_bus.wdata[supply_ctrl_pkg::CTRL_PRE_CLR])) begin
      for (int k = 0; k < supply_ctrl_pkg::PRE_DEPTH; k++) begin
        pre_v[k] <= 16'h0000;
        pre_c[k] <= 16'h0000;
      end
    end else begin
      if (wr_pv) begin
        pre_v[idx_r] <= clamp16(i_bus.wdata[15:0], 16'h0000,
                                supply_ctrl_pkg::RATED);
      end
      if (wr_pc) begin
        pre_c[idx_r] <= clamp16(i_bus.wdata[15:0], 16'h0000,
                                supply_ctrl_pkg::RATED);
      end
    end
  end

  // stage and display outputs follow setpoints; recall never sets output on
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_volt_set  <= 16'h0000;
      o_curr_set  <= 16'h0000;
      o_disp_volt <= 16'h0000;
      o_disp_curr <= 16'h0000;
      o_ramp_up   <= 8'h00;
      o_ramp_dn   <= 8'h00;
    end else begin
      o_volt_set  <= volt_r;
      o_curr_set  <= curr_r;
      o_disp_volt <= volt_r;
      o_disp_curr <= curr_r;
      o_ramp_up   <= rup_r;
      o_ramp_dn   <= rdn_r;
    end
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || !i_bus.rd) begin
      o_rdata <= 32'h00000000;
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_CTRL) begin
      o_rdata <= {29'h00000000, pon_last_r, foldback_r, out_req_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_STATUS) begin
      o_rdata <= {25'h0000000, foldback_r, ac_l_r, ot_l_r, oc_l_r, ov_l_r,
                  trip_r, o_out_en};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_CURR_SET) begin
      o_rdata <= {16'h0000, curr_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_VOLT_SET) begin
      o_rdata <= {16'h0000, volt_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_OC_LIMIT) begin
      o_rdata <= {16'h0000, lim_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_RAMP_UP) begin
      o_rdata <= {24'h000000, rup_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_RAMP_DN) begin
      o_rdata <= {24'h000000, rdn_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_IDX) begin
      o_rdata <= {28'h0000000, idx_r};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_VOLT) begin
      o_rdata <= {16'h0000, pre_v[idx_r]};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_CURR) begin
      o_rdata <= {16'h0000, pre_c[idx_r]};
    end else if (i_bus.addr == supply_ctrl_pkg::ADDR_PRE_LIST) begin
      o_rdata <= {pre_v[idx_r], pre_c[idx_r]};
    end else begin
      o_rdata <= 32'h00000000; // unmapped reads zero
    end
  end

endmodule : supply_protect_preset_ctrl

// [supply_protect_preset_ctrl_assertions.sv]
// checker: bus answer, fault, setpoint and output-enable timing properties
`timescale 1ns/100ps
module supply_protect_preset_ctrl_chk #(
  parameter int TRIP_CYCLES = 20 // foldback delay, handed on by the bind
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_nrst,
  input wire supply_ctrl_pkg::bus_req_t  i_bus,
  input wire supply_ctrl_pkg::fault_in_t i_fault,
  input wire logic                       i_cc_mode,
  input wire logic [15:0]                i_meas_curr,
  input wire logic                       i_local,
  input wire logic [31:0]                o_rdata,
  input wire logic                       o_out_en,
  input wire logic [15:0]                o_volt_set,
  input wire logic [15:0]                o_curr_set,
  input wire logic [15:0]                o_disp_volt,
  input wire logic [15:0]                o_disp_curr,
  input wire logic [7:0]                 o_ramp_up,
  input wire logic [7:0]                 o_ramp_dn
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // write to the control word, and clamped forms of the write data
  wire logic       ctrl_wr  = i_bus.wr && (i_bus.addr == supply_ctrl_pkg::ADDR_CTRL);
  wire logic [15:0] curr_cl = (i_bus.wdata > 32'h3E8) ? 16'h03E8 : i_bus.wdata[15:0];
  wire logic [7:0]  ramp_cl = (i_bus.wdata > 32'h63) ? 8'h63 : i_bus.wdata[7:0];
  a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_rd: assert property (
    i_bus.rd && i_bus.addr > 8'h2C |=> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_fault_off: assert property (
    (i_fault.ov || i_fault.oc) |-> ##[1:2] !o_out_en)
    else $error("output stayed on during a latching fault");
  a_clr_blocked: assert property (
    ctrl_wr && i_bus.wdata[3] && (i_fault.ov || i_fault.oc) |=> !o_out_en [*3])
    else $error("clear took effect with a fault present");
  a_curr_wr: assert property (
    i_bus.wr && i_bus.addr == supply_ctrl_pkg::ADDR_CURR_SET
    |-> ##2 o_curr_set == $past(curr_cl, 2))
    else $error("current setpoint output wrong after write");
  a_ramp_wr: assert property (
    i_bus.wr && i_bus.addr == supply_ctrl_pkg::ADDR_RAMP_UP
    |-> ##2 o_ramp_up == $past(ramp_cl, 2))
    else $error("ramp-up output wrong after write");
  a_ramp_range: assert property (
    o_ramp_up <= 8'h63 && o_ramp_dn <= 8'h63)
    else $error("ramp time beyond its range");
  a_disp_match: assert property (
    o_disp_volt == o_volt_set && o_disp_curr == o_curr_set)
    else $error("displays differ from setpoints");
  a_out_en_cause: assert property (
    $rose(o_out_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("output enabled without a control write");
  a_pon_off: assert property (
    $rose(i_nrst) |-> !o_out_en && o_rdata == 32'h0)
    else $error("output not off after reset");
  c_recall: cover property (ctrl_wr && i_bus.wdata[6]);
  c_clear_ok: cover property (ctrl_wr && i_bus.wdata[3] ##3 o_out_en);
  c_forced_off: cover property ($fell(o_out_en));
endmodule : supply_protect_preset_ctrl_chk

bind supply_protect_preset_ctrl supply_protect_preset_ctrl_chk #(.TRIP_CYCLES(TRIP_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_bus(i_bus), .i_fault(i_fault),
  .i_cc_mode(i_cc_mode), .i_meas_curr(i_meas_curr), .i_local(i_local), .o_rdata(o_rdata),
  .o_out_en(o_out_en), .o_volt_set(o_volt_set), .o_curr_set(o_curr_set),
  .o_disp_volt(o_disp_volt), .o_disp_curr(o_disp_curr), .o_ramp_up(o_ramp_up),
  .o_ramp_dn(o_ramp_dn));

// [supply_protect_preset_ctrl_tb_top.sv]
// testbench: random and corner-case command traffic with self-checking compares
`timescale 1ns/100ps
module supply_protect_preset_ctrl_tb_top;
  localparam int TRIP = 20; // shortened foldback delay
  logic                       clk   = 1'b0;
  logic                       nrst  = 1'b0;
  supply_ctrl_pkg::bus_req_t  bus;
  supply_ctrl_pkg::fault_in_t fault = '0;
  logic                       cc    = 1'b0;
  logic [15:0]                meas  = 16'h0000;
  logic                       loc   = 1'b0;
  logic [31:0]                rdata, got;
  logic                       out_en;
  logic [15:0]                vset, cset, dvolt, dcurr, v, pv[16], pc[16];
  logic [7:0]                 rup, rdn;
  int                         miscompares = 0;
  int                         cmp_count = 0;
  int                         cycles = 0;
  always #50 clk = ~clk;
  supply_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_bus(bus));
  supply_protect_preset_ctrl #(.TRIP_CYCLES(TRIP)) uut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_bus(bus), .i_fault(fault), .i_cc_mode(cc),
    .i_meas_curr(meas), .i_local(loc), .o_rdata(rdata), .o_out_en(out_en),
    .o_volt_set(vset), .o_curr_set(cset), .o_disp_volt(dvolt), .o_disp_curr(dcurr),
    .o_ramp_up(rup), .o_ramp_dn(rdn));
  // random value within a legal range
  function automatic logic [15:0] rnd(input int lo, input int hi);
    return 16'(lo + $urandom % (hi - lo + 1));
  endfunction : rnd
  // expected status word
  function automatic logic [31:0] st(input logic fold, ac, ot, oc, ov, trip, on);
    return {25'h0, fold, ac, ot, oc, ov, trip, on};
  endfunction : st
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // read through the host and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    host.rd(a, got);
    chk(what, exp, got);
  endtask : rc
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    got = $urandom(32'h1597d0b9);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk("out_en_rst", 32'h0, out_en);
    rc(supply_ctrl_pkg::ADDR_OC_LIMIT, 32'h44C, "limit_rst");
    // current setpoint: top, bottom, random
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 16'h03E8 : (k == 1) ? 16'h0000 : rnd(100, 1000);
      host.wr(supply_ctrl_pkg::ADDR_CURR_SET, v);
      rc(supply_ctrl_pkg::ADDR_CURR_SET, v, "curr_set");
      chk("curr_pins", {v, v}, {cset, dcurr});
    end
    host.wr(8'hF0, 32'hFFFF_FFFF);
    rc(8'hF0, 32'h0, "unmapped");
    $display("test setpoint done");
    got = 32'(rnd(100, 1100));
    host.wr(supply_ctrl_pkg::ADDR_OC_LIMIT, got);
    loc <= 1'b1;
    rc(supply_ctrl_pkg::ADDR_OC_LIMIT, got, "limit_local");
    host.wr(supply_ctrl_pkg::ADDR_OC_CMD, supply_ctrl_pkg::OC_KEY_MIN);
    rc(supply_ctrl_pkg::ADDR_OC_LIMIT, v, "limit_min");
    host.wr(supply_ctrl_pkg::ADDR_OC_CMD, supply_ctrl_pkg::OC_KEY_MAX);
    rc(supply_ctrl_pkg::ADDR_OC_LIMIT, 32'h44C, "limit_max");
    host.wr(supply_ctrl_pkg::ADDR_OC_LIMIT, 32'hC8);
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h10);
    rc(supply_ctrl_pkg::ADDR_OC_LIMIT, 32'h44C, "limit_devrst");
    $display("test limit done");
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'h0063 : (k == 1) ? 16'h0000 : rnd(0, 99);
      host.wr(supply_ctrl_pkg::ADDR_RAMP_UP, v);
      host.wr(supply_ctrl_pkg::ADDR_RAMP_DN, 16'h0063 - v);
      rc(supply_ctrl_pkg::ADDR_RAMP_UP, v, "ramp_up");
      rc(supply_ctrl_pkg::ADDR_RAMP_DN, 16'h0063 - v, "ramp_dn");
      chk("ramp_pins", {v[7:0], 8'h63 - v[7:0]}, {rup, rdn});
    end
    $display("test ramp done");
    for (int i = 0; i < 16; i++) begin
      pv[i] = rnd(0, 1000);
      pc[i] = rnd(0, 1000);
      host.wr(supply_ctrl_pkg::ADDR_PRE_IDX, i);
      host.wr(supply_ctrl_pkg::ADDR_PRE_VOLT, pv[i]);
      host.wr(supply_ctrl_pkg::ADDR_PRE_CURR, pc[i]);
    end
    for (int i = 0; i < 16; i++) begin
      host.wr(supply_ctrl_pkg::ADDR_PRE_IDX, i);
      rc(supply_ctrl_pkg::ADDR_PRE_VOLT, pv[i], "pre_volt");
      rc(supply_ctrl_pkg::ADDR_PRE_CURR, pc[i], "pre_curr");
      rc(supply_ctrl_pkg::ADDR_PRE_LIST, {pv[i], pc[i]}, "pre_list");
    end
    // recall with the output off, then on
    for (int k = 0; k < 2; k++) begin
      host.wr(supply_ctrl_pkg::ADDR_PRE_IDX, 3 + 2 * k);
      host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h40 | k);
      repeat (3) @(negedge clk);
      chk("recall", {pv[3+2*k], pc[3+2*k]}, {vset, cset});
      chk("recall_disp", {pv[3+2*k], pc[3+2*k]}, {dvolt, dcurr});
      chk("recall_out", k, out_en);
    end
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h21);
    for (int i = 0; i < 16; i++) begin
      host.wr(supply_ctrl_pkg::ADDR_PRE_IDX, i);
      rc(supply_ctrl_pkg::ADDR_PRE_LIST, 32'h0, "pre_erased");
    end
    $display("test preset done");
    fault.ov <= 1'b1;
    repeat (3) @(posedge clk);
    fault.ov <= 1'b0;
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 0, 1, 0, 0), "ov_latched");
    fault.oc <= 1'b1;
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h9);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 1, 1, 0, 0), "clr_blocked");
    fault.oc <= 1'b0;
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h9);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 1), "clr_ok");
    fault.ot <= 1'b1;
    repeat (3) @(posedge clk);
    fault.ot <= 1'b0;
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 1, 0, 0, 0, 0), "ot_latched");
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h9);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 1), "ot_cleared");
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h4);
    fault.ac <= 1'b1;
    repeat (3) @(posedge clk);
    fault.ac <= 1'b0;
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 0), "ac_unlatched");
    $display("test fault done");
    host.wr(supply_ctrl_pkg::ADDR_OC_LIMIT, 32'h1F4);
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h3);
    rc(supply_ctrl_pkg::ADDR_CTRL, 32'h3, "fold_query");
    cc <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      meas <= 16'h0258;
      repeat ((k == 2) ? TRIP + 5 : TRIP - 5) @(posedge clk);
      meas <= (k == 2) ? 16'h0258 : 16'h0190;
      @(posedge clk);
    end
    rc(supply_ctrl_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0, 1, 0), "tripped");
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'hB);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0, 1, 0), "trip_held");
    meas <= 16'h0190;
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'hB);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0, 0, 1), "trip_clr");
    host.wr(supply_ctrl_pkg::ADDR_CTRL, 32'h1);
    meas <= 16'h0258;
    repeat (TRIP + 5) @(posedge clk);
    rc(supply_ctrl_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0, 0, 1), "fold_off");
    rc(supply_ctrl_pkg::ADDR_CTRL, 32'h1, "fold_query_off");
    $display("test foldback done");
    final_report();
  end
endmodule : supply_protect_preset_ctrl_tb_top
